// file: src/tx_lane_pkg.sv
/*
 Constants and types for the transmit byte-lane selector.
 Assumes a 4-bit character-length field and 16-bit sync and data words.
*/
package tx_lane_pkg;
    localparam int CNT_W = 4;
    localparam int WORD_W = 16;
    localparam logic [3:0] BITPOS_LOAD = 4'h0; // Bit-position counter always loads zero
    localparam logic [3:0] OVF_COUNT = 4'hf; // Minus one: overflow pulse is high here
    localparam logic [3:0] OVF_LEAD = 4'he; // Count just before the overflow pulse
    localparam logic [3:0] LEN_RESET = 4'h0;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic MARK_LEVEL = 1'b1; // Line idle level, logical one
    localparam int LEN_DOUBLE_BIT = 3; // Top bit of the length field

    // One-hot character-type enables, priority order escape to pad
    typedef enum logic [5:0] {
        SEND_IDLE = 6'h01,
        SEND_ESC = 6'h02,
        SEND_CHECK = 6'h04,
        SEND_SYNC = 6'h08,
        SEND_DATA = 6'h10,
        SEND_PAD = 6'h20
    } sendSel_t;
endpackage

// file: src/tx_byte_lane_select.sv
/*
 Transmit byte-lane selector: character-length and bit-position counters,
 send-enable priority, byte-lane toggle and second-character flag.
 Assumes the transmit bit clock arrives as an asynchronous pin and that
 dataLoad is a core_clk pulse from the shift-register loader.
*/
`timescale 1ns/1ns

module tx_byte_lane_select
    import tx_lane_pkg::*;
#(
    parameter int LEN_W = CNT_W
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic txClkPin,
    input wire logic [LEN_W-1:0] lengthField,
    input wire logic escReq,
    input wire logic checkReq,
    input wire logic syncReq,
    input wire logic dataReq,
    input wire logic padReq,
    input wire logic dataLoad,
    input wire logic [WORD_W-1:0] syncWord,
    input wire logic [WORD_W-1:0] dataWord,
    input wire logic otherBit,
    output logic syncEnLo,
    output logic syncEnHi,
    output logic dataEnLo,
    output logic dataEnHi,
    output logic [2:0] bitSelect,
    output logic overflowPulse,
    output logic secondPending,
    output logic byteLaneToggle,
    output logic txActive,
    output sendSel_t sendState,
    output logic serialOut
);
    logic [2:0] sync_r, sync_nxt;
    logic clkLvl_r, clkLvl_nxt;
    logic txRise;
    logic [LEN_W-1:0] charLen_r, charLen_nxt;
    logic [3:0] bitPos_r, bitPos_nxt;
    logic active_r, active_nxt;
    sendSel_t send_r, send_nxt;
    logic pending_r, pending_nxt;
    logic toggle_r, toggle_nxt;
    logic wasData_r, wasData_nxt;
    logic serial_r, serial_nxt;
    logic ovf, lead, doubleMode, laneSel, muxOn, dataOk;
    logic [3:0] bitIdx;

    // Priority grant for the next character type
    function automatic sendSel_t grant(input logic e, input logic c, input logic s, input logic d,
                                       input logic p);
        sendSel_t g;
        g = SEND_IDLE;
        if (e) begin
            g = SEND_ESC;
        end else if (c) begin
            g = SEND_CHECK;
        end else if (s) begin
            g = SEND_SYNC;
        end else if (d) begin
            g = SEND_DATA;
        end else if (p) begin
            g = SEND_PAD;
        end
        return g;
    endfunction

    // Pin synchroniser; an edge counts once stages two and three agree
    always_comb begin
        sync_nxt = {sync_r[1:0], txClkPin};
        clkLvl_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : clkLvl_r;
    end
    assign txRise = (sync_r[1] == sync_r[2]) && sync_r[2] && !clkLvl_r;

    // Overflow pulse is the minus-one count; lead is the edge entering it
    assign ovf = active_r && (charLen_r == OVF_COUNT);
    assign lead = txRise && active_r && (charLen_r == OVF_LEAD);
    assign doubleMode = lengthField[LEN_DOUBLE_BIT];
    assign laneSel = bitPos_r[3] | toggle_r;
    assign muxOn = !ovf;

    // Character-count flags; the dataLoad set outranks the edge updates, single mode clears both
    // Lead re-grants send_r, so the trailing edge uses the type that just ended
    always_comb begin
        pending_nxt = pending_r;
        toggle_nxt = toggle_r;
        wasData_nxt = wasData_r;
        if (lead) begin
            wasData_nxt = (send_r == SEND_DATA);
        end
        if (dataLoad) begin
            pending_nxt = 1'b1;
            toggle_nxt = 1'b0;
        end else if (lead && send_r == SEND_DATA) begin
            pending_nxt = !toggle_r;
        end else if (txRise && ovf && wasData_r) begin
            toggle_nxt = !toggle_r;
        end
        if (!doubleMode) begin
            pending_nxt = 1'b0;
            toggle_nxt = 1'b0;
        end
    end

    // Counters and send enables advance on transmit clock edges only
    always_comb begin
        charLen_nxt = charLen_r;
        bitPos_nxt = bitPos_r;
        active_nxt = active_r;
        send_nxt = send_r;
        dataOk = dataReq | pending_nxt;
        if (txRise) begin
            if (!active_r) begin
                charLen_nxt = lengthField;
                bitPos_nxt = BITPOS_LOAD;
                send_nxt = grant(escReq, checkReq, syncReq, dataOk, padReq);
                active_nxt = (send_nxt != SEND_IDLE);
            end else if (ovf) begin
                charLen_nxt = lengthField;
                bitPos_nxt = BITPOS_LOAD;
                active_nxt = (send_r != SEND_IDLE);
            end else begin
                charLen_nxt = charLen_r + 4'h1;
                bitPos_nxt = bitPos_r + 4'h1;
                if (lead) begin
                    send_nxt = grant(escReq, checkReq, syncReq, dataOk, padReq);
                end
            end
        end
    end

    // Sync and data bits come from the selected lane, other types from otherBit; idle rests at mark
    always_comb begin
        bitIdx = {laneSel, bitPos_r[2:0]};
        case (send_r)
            SEND_IDLE: serial_nxt = MARK_LEVEL;
            SEND_SYNC: serial_nxt = syncWord[bitIdx];
            SEND_DATA: serial_nxt = dataWord[bitIdx];
            default: serial_nxt = otherBit;
        endcase
        if (!active_r) begin
            serial_nxt = MARK_LEVEL;
        end
    end

    // Register everything; synchronous reset
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            sync_r <= SYNC_RESET;
            clkLvl_r <= 1'b0;
            charLen_r <= LEN_RESET;
            bitPos_r <= BITPOS_LOAD;
            active_r <= 1'b0;
            send_r <= SEND_IDLE;
            pending_r <= 1'b0;
            toggle_r <= 1'b0;
            wasData_r <= 1'b0;
            serial_r <= MARK_LEVEL;
        end else begin
            sync_r <= sync_nxt;
            clkLvl_r <= clkLvl_nxt;
            charLen_r <= charLen_nxt;
            bitPos_r <= bitPos_nxt;
            active_r <= active_nxt;
            send_r <= send_nxt;
            pending_r <= pending_nxt;
            toggle_r <= toggle_nxt;
            wasData_r <= wasData_nxt;
            serial_r <= serial_nxt;
        end
    end

    // Lane enables are gated by the strobe; handshake-style outputs
    assign syncEnLo = muxOn && active_r && send_r == SEND_SYNC && !laneSel;
    assign syncEnHi = muxOn && active_r && send_r == SEND_SYNC && laneSel;
    assign dataEnLo = muxOn && active_r && send_r == SEND_DATA && !laneSel;
    assign dataEnHi = muxOn && active_r && send_r == SEND_DATA && laneSel;
    assign bitSelect = bitPos_r[2:0];
    assign overflowPulse = ovf;
    assign secondPending = pending_r;
    assign byteLaneToggle = toggle_r;
    assign txActive = active_r;
    assign sendState = send_r;
    assign serialOut = serial_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    // Checks on selector, counters and flags
    AST_SEL_LOW: assert property ((muxOn && !bitPos_r[3] && !toggle_r && send_r == SEND_SYNC && active_r)
        |-> syncEnLo && !syncEnHi) else $error("low sync enable missing");
    AST_STROBE_OFF: assert property (ovf |-> !(syncEnLo | syncEnHi | dataEnLo | dataEnHi))
        else $error("lane enable during overflow");
    AST_HIGH_AT8: assert property ((active_r && !ovf && send_r == SEND_SYNC && bitPos_r == 4'h8)
        |-> syncEnHi) else $error("high sync byte not selected at count 8");
    AST_RELOAD: assert property ((txRise && ovf)
        |=> (bitPos_r == BITPOS_LOAD && charLen_r == $past(lengthField)))
        else $error("counters not reloaded after overflow");
    AST_SINGLE_CLR: assert property (!doubleMode |=> !pending_r && !toggle_r)
        else $error("single mode flags not held clear");
    AST_NODATA_HOLD: assert property ((txRise && send_r != SEND_DATA && !dataLoad && doubleMode)
        |=> pending_r == $past(pending_r)) else $error("pending changed without data");
    AST_LOAD_SET: assert property ((dataLoad && doubleMode) |=> pending_r && !toggle_r)
        else $error("data load did not set pending");
    AST_TRAIL_SET: assert property ((txRise && ovf && wasData_r && !toggle_r && !dataLoad && doubleMode)
        |=> toggle_r && pending_r == $past(pending_r))
        else $error("toggle not set on first trailing edge");
    AST_LEAD_CLR: assert property ((lead && send_r == SEND_DATA && toggle_r && !dataLoad)
        |=> !pending_r) else $error("pending not cleared on second lead");
    AST_PRIO: assert property ((txRise && !active_r && escReq) |=> send_r == SEND_ESC)
        else $error("escape not granted first");
    AST_MARK: assert property ((!active_r) |=> serial_r == MARK_LEVEL)
        else $error("line not at mark when idle");
    AST_DATA_LO: assert property ((!ovf && active_r && send_r == SEND_DATA && !bitPos_r[3] && !toggle_r)
        |-> dataEnLo && !dataEnHi) else $error("low data enable missing");

    COV_SYNC_HI: cover property (syncEnLo ##[1:400] syncEnHi);
    COV_DOUBLE: cover property (dataEnLo ##[1:400] dataEnHi);
    COV_SECOND_DONE: cover property (toggle_r ##[1:400] !toggle_r && !pending_r);
    COV_IDLE: cover property (active_r ##1 !active_r);
endmodule

// file: bench/modem_clock_model.sv
/*
 Modem-side source of the transmit bit clock.
 Assumes the bench raises runClk only while characters are to be sent.
*/
`timescale 1ns/1ns
module modem_clock_model #(
    parameter int HALF_NS = 400
) (
    input wire logic runClk,
    output logic txClk
);
    // Stands low between frames; odd start offset keeps phase apart from the core clock
    initial begin
        txClk = 1'b0;
        #37;
        forever begin
            wait (runClk === 1'b1);
            #(HALF_NS) txClk = 1'b1;
            #(HALF_NS) txClk = 1'b0;
        end
    end
endmodule

// file: bench/tx_byte_lane_select_test.sv
/*
 Self-checking bench for the transmit byte-lane selector.
 Assumes the package, the design and the modem clock model compile first.
*/
`timescale 1ns/1ns
module tx_byte_lane_select_test;
    import tx_lane_pkg::*;
    logic core_clk, reset_n, txClkPin, runClk, escReq, checkReq, syncReq, dataReq, padReq, dataLoad, otherBit;
    logic [3:0] lengthField;
    logic [15:0] syncWord, dataWord;
    logic syncEnLo, syncEnHi, dataEnLo, dataEnHi, overflowPulse, secondPending, byteLaneToggle, txActive, serialOut;
    logic [2:0] bitSelect;
    sendSel_t sendState;
    logic [10:0] expQ[$];
    logic [10:0] seen;
    int n_mismatch = 0;
    int check_count = 0;
    int seed = 32'h04bc;
    tx_byte_lane_select dut (.core_clk(core_clk), .reset_n(reset_n), .txClkPin(txClkPin),
        .lengthField(lengthField), .escReq(escReq), .checkReq(checkReq), .syncReq(syncReq), .dataReq(dataReq),
        .padReq(padReq), .dataLoad(dataLoad), .syncWord(syncWord), .dataWord(dataWord), .otherBit(otherBit),
        .syncEnLo(syncEnLo), .syncEnHi(syncEnHi), .dataEnLo(dataEnLo), .dataEnHi(dataEnHi), .bitSelect(bitSelect),
        .overflowPulse(overflowPulse), .secondPending(secondPending), .byteLaneToggle(byteLaneToggle),
        .txActive(txActive), .sendState(sendState), .serialOut(serialOut));
    modem_clock_model modem (.runClk(runClk), .txClk(txClkPin));
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task automatic check(input string what, input logic [10:0] e, input logic [10:0] s);
        check_count++;
        if (s !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, e, s);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Last state before overflow tells which lane served the character
    always @(posedge core_clk) if (overflowPulse !== 1'b1) seen <= {sendState, syncEnLo, syncEnHi, dataEnLo,
        dataEnHi, byteLaneToggle};
    always @(posedge overflowPulse) begin
        #1;
        check("enables in overflow", 11'h0, 11'({syncEnLo, syncEnHi, dataEnLo, dataEnHi}));
        check("bit select at overflow", 11'(3'h7 - lengthField[2:0]), 11'(bitSelect));
        if (expQ.size() == 0) check("unplanned character", 11'h0, 11'h7ff);
        else check("character lanes", expQ.pop_front(), seen);
    end
    // Drops requests once the last wanted character has been granted
    task automatic run(input int n);
        runClk = 1'b1;
        wait (txActive === 1'b1);
        repeat (n - 1) @(posedge overflowPulse);
        @(posedge core_clk);
        #1;
        {escReq, checkReq, syncReq, dataReq, padReq} = 5'h0;
        wait (txActive === 1'b0);
        runClk = 1'b0;
        repeat (12) @(posedge core_clk);
        #1;
        check("line at mark", 11'h1, 11'(serialOut));
    endtask
    task automatic load_word;
        dataWord = 16'($random(seed));
        dataLoad = 1'b1;
        @(posedge core_clk);
        #1;
        dataLoad = 1'b0;
    endtask
    initial begin
        #2_000_000;
        n_mismatch++;
        finish_test;
    end
    initial begin
        {reset_n, runClk, lengthField, dataLoad, escReq, checkReq, syncReq, dataReq, padReq} = '0;
        otherBit = 1'b1;
        dataWord = 16'h0;
        syncWord = 16'h9696;
        repeat (3) @(posedge core_clk);
        #1;
        reset_n = 1'b1;
        check("idle after reset", {SEND_IDLE, 5'h0}, {sendState, syncEnLo, syncEnHi, dataEnLo, dataEnHi,
            byteLaneToggle});
        check("mark level", 11'h1, 11'(serialOut));
        // Short sync twice: low sync byte only, toggle untouched
        lengthField = 4'h8;
        syncReq = 1'b1;
        repeat (2) expQ.push_back({SEND_SYNC, 5'h10});
        run(2);
        check("flags after sync", 11'h0, 11'({secondPending, byteLaneToggle}));
        // Twelve-bit sync ends on the high sync byte
        syncWord = 16'h0abc;
        lengthField = 4'h4;
        syncReq = 1'b1;
        expQ.push_back({SEND_SYNC, 5'h08});
        run(1);
        // Double-character data: low byte, then high byte with toggle set
        lengthField = 4'h8;
        load_word();
        check("pending after load", 11'h2, 11'({secondPending, byteLaneToggle}));
        expQ.push_back({SEND_DATA, 5'h04});
        expQ.push_back({SEND_DATA, 5'h03});
        run(2);
        check("flags after pair", 11'h0, 11'({secondPending, byteLaneToggle}));
        // Single-character data keeps the pending flag clear
        lengthField = 4'h0;
        load_word();
        check("pending in single mode", 11'h0, 11'(secondPending));
        dataReq = 1'b1;
        expQ.push_back({SEND_DATA, 5'h02});
        run(1);
        // Random request mixes; never all clear, or nothing would start
        repeat (6) begin
            {escReq, checkReq, syncReq, dataReq, padReq} = 5'($random(seed));
            otherBit = 1'($random(seed));
            if ({escReq, checkReq, syncReq, dataReq} == 4'h0) padReq = 1'b1;
            if (escReq) expQ.push_back({SEND_ESC, 5'h0});
            else if (checkReq) expQ.push_back({SEND_CHECK, 5'h0});
            else if (syncReq) expQ.push_back({SEND_SYNC, 5'h08});
            else if (dataReq) expQ.push_back({SEND_DATA, 5'h02});
            else expQ.push_back({SEND_PAD, 5'h0});
            run(1);
        end
        check("leftover notes", 11'h0, 11'(expQ.size()));
        finish_test;
    end
endmodule
